// ==== logic/acc_pkg.sv ====
// Purpose: shared constants and types of the computation control block
// Assumes: registers are reached as word indices; byte address = 4 * index
// Notes:   timing counts are in conversion clock ticks of 4 system clock cycles at 250 MHz
package acc_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_PRE_SAMPLE = 12'hF54;
  localparam logic [11:0] IDX_ACC_MODE   = 12'hF55;
  localparam logic [11:0] IDX_THR_CTRL   = 12'hF56;
  localparam logic [11:0] IDX_PRE_COUNT  = 12'hF59;
  localparam logic [11:0] IDX_CONV_CTRL  = 12'hF5B;
  localparam logic [11:0] IDX_PREV       = 12'hF5C;
  localparam logic [11:0] IDX_RESULT     = 12'hF5E;
  localparam logic [11:0] IDX_STATUS     = 12'hF60;
  localparam logic [11:0] IDX_RPT        = 12'hF61;
  localparam logic [11:0] IDX_CNT        = 12'hF62;
  localparam logic [11:0] IDX_LOWER      = 12'hF65;
  localparam logic [11:0] IDX_UPPER      = 12'hF67;
  localparam logic [11:0] IDX_ERROR      = 12'hF69;
  localparam logic [11:0] IDX_ACCUM      = 12'hF6B;
  localparam logic [11:0] IDX_FILTER     = 12'hF6D;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PS_PPOL  = 7;
  localparam int PS_IPEN  = 6;
  localparam int PS_GPOL  = 5;
  localparam int PS_DSEN  = 0;
  localparam int AM_PSIS  = 7;
  localparam int AM_CRS   = 4;
  localparam int AM_ACLR  = 3;
  localparam int AM_MD    = 0;
  localparam int TC_CALC  = 4;
  localparam int TC_SOI   = 3;
  localparam int TC_TMD   = 0;
  localparam int ST_AOV   = 7;
  localparam int ST_UTHR  = 6;
  localparam int ST_LTHR  = 5;
  localparam int ST_MATH  = 4;
  localparam int ST_TIF   = 3;
  localparam int CC_CONT  = 6;
  localparam int CC_CS    = 4;
  localparam int CC_GO    = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ---------------------------------------------------------------
  // timing: conversion clock and acquisition length
  // ---------------------------------------------------------------
  localparam int CONV_CLK_NS  = 16;
  localparam int SYS_CLK_NS   = 4;
  localparam int CONV_DIV     = CONV_CLK_NS / SYS_CLK_NS;
  localparam int ACQ_TICKS    = 2;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACCUM = 3'h1;
  localparam logic [2:0] MD_AVG   = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF   = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} acc_stage_t;
endpackage

// ==== logic/acc_compute_ctrl.sv ====
// Purpose: control and status of the ADC computation stage, classic Wishbone slave
// Assumes: analog core answers each conversion with conv_done_i and conv_data_i
// Notes:   error value and its overflow come from an external error calculator
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
module acc_compute_ctrl (
  input  wire logic        clk_i,          // system clock, 250 MHz
  input  wire logic        rst_i,          // synchronous reset, active high
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // wishbone write enable
  input  wire logic [31:0] wb_adr_i,       // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // wishbone byte enables
  input  wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic      [31:0] wb_dat_o,       // wishbone read data
  output logic             wb_ack_o,       // wishbone acknowledge
  input  wire logic        conv_done_i,    // analog core finished a conversion
  input  wire logic [9:0]  conv_data_i,    // conversion data, stable with done
  input  wire logic [15:0] error_value_i,  // signed error from error calculator
  input  wire logic        error_ovf_i,    // error calculation overflowed
  output logic             precharge_o,    // precharge stage active
  output logic             pre_drive_hi_o, // 1 short to analog supply, 0 to ground
  output logic             guard_o,        // guard ring level
  output logic             acquire_o,      // acquisition stage active
  output logic             convert_o,      // conversion stage active
  output logic [2:0]       err_calc_mode_o,// error calculation mode
  output logic             thr_flag_o      // threshold interrupt flag level
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE_F = acc_pkg::RST_BYTE;
  localparam logic [15:0] RST_WORD_F = acc_pkg::RST_WORD;
  logic [7:0]  pre_sample_reg, acc_mode_reg, thr_ctrl_reg, pre_count_reg;
  logic [7:0]  rpt_reg, cnt_reg;
  logic        cont_reg, clk_src_reg, go_reg;
  logic        aov_reg, math_reg, tif_reg;
  logic [15:0] lower_reg, upper_reg, prev_reg, result_reg, filter_reg;
  logic [17:0] accum_reg;
  logic        clr_busy_reg;
  acc_pkg::acc_stage_t stage_reg;
  logic        second_reg;
  logic [7:0]  tick_cnt_reg;
  logic [$clog2(acc_pkg::CONV_DIV)-1:0] div_reg;
  logic        tick;
  logic        done_s1_reg, done_s2_reg, done_s3_reg, done_evt;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        req, wr, hit_high;
  logic [11:0] idx;
  logic [7:0]  wbyte;
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign hit_high = wb_sel_i[1];
  assign idx      = wb_adr_i[13:2];
  assign wbyte    = wb_dat_i[7:0];

  // ---------------------------------------------------------------
  // field views
  // ---------------------------------------------------------------
  logic       ppol, ipen, gpol, dsen, psis;
  logic [2:0] crs, mode, tmd;
  logic       soi;
  assign ppol = pre_sample_reg[acc_pkg::PS_PPOL];
  assign ipen = pre_sample_reg[acc_pkg::PS_IPEN];
  assign gpol = pre_sample_reg[acc_pkg::PS_GPOL];
  assign dsen = pre_sample_reg[acc_pkg::PS_DSEN];
  assign psis = acc_mode_reg[acc_pkg::AM_PSIS];
  assign crs  = acc_mode_reg[acc_pkg::AM_CRS +: 3];
  assign mode = acc_mode_reg[acc_pkg::AM_MD +: 3];
  assign tmd  = thr_ctrl_reg[acc_pkg::TC_TMD +: 3];
  assign soi  = thr_ctrl_reg[acc_pkg::TC_SOI];

  // ---------------------------------------------------------------
  // conversion clock enable and done synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || div_reg == ($clog2(acc_pkg::CONV_DIV))'(acc_pkg::CONV_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = (div_reg == '0);

  // done crosses from the analog core, the second and third stages give its rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      done_s1_reg <= conv_done_i;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end
  assign done_evt = done_s2_reg & ~done_s3_reg;

  // ---------------------------------------------------------------
  // stage sequencer
  // ---------------------------------------------------------------
  logic conv_end, pair_end, start_evt;
  assign conv_end  = (stage_reg == acc_pkg::ST_CONV) && done_evt;
  assign pair_end  = conv_end && (!dsen || second_reg);
  assign start_evt = (stage_reg == acc_pkg::ST_IDLE) && go_reg && !clr_busy_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg    <= acc_pkg::ST_IDLE;
      second_reg   <= 1'b0;
      tick_cnt_reg <= RST_BYTE_F;
    end else begin
      case (stage_reg)
        acc_pkg::ST_IDLE: begin
          second_reg <= 1'b0;
          if (start_evt) begin
            tick_cnt_reg <= pre_count_reg;
            stage_reg    <= (pre_count_reg != 8'h00) ? acc_pkg::ST_PRE
                                                      : acc_pkg::ST_ACQ;
            if (pre_count_reg == 8'h00) begin
              tick_cnt_reg <= 8'(acc_pkg::ACQ_TICKS);
            end
          end
        end
        acc_pkg::ST_PRE: begin
          if (tick) begin
            if (tick_cnt_reg == 8'h01) begin
              stage_reg    <= acc_pkg::ST_ACQ;
              tick_cnt_reg <= 8'(acc_pkg::ACQ_TICKS);
            end else begin
              tick_cnt_reg <= tick_cnt_reg - 8'h01;
            end
          end
        end
        acc_pkg::ST_ACQ: begin
          if (tick) begin
            if (tick_cnt_reg == 8'h01) begin
              stage_reg <= acc_pkg::ST_CONV;
            end else begin
              tick_cnt_reg <= tick_cnt_reg - 8'h01;
            end
          end
        end
        acc_pkg::ST_CONV: begin
          if (done_evt) begin
            if (dsen && !second_reg) begin
              second_reg   <= 1'b1;
              tick_cnt_reg <= pre_count_reg;
              stage_reg    <= (pre_count_reg != 8'h00) ? acc_pkg::ST_PRE
                                                        : acc_pkg::ST_ACQ;
              if (pre_count_reg == 8'h00) begin
                tick_cnt_reg <= 8'(acc_pkg::ACQ_TICKS);
              end
            end else begin
              stage_reg <= acc_pkg::ST_IDLE;
            end
          end
        end
        default: stage_reg <= acc_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // analog-facing outputs
  // ---------------------------------------------------------------
  logic inv;
  assign inv = dsen && ipen && second_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      precharge_o    <= 1'b0;
      pre_drive_hi_o <= 1'b0;
      guard_o        <= 1'b0;
      acquire_o      <= 1'b0;
      convert_o      <= 1'b0;
    end else begin
      precharge_o    <= (stage_reg == acc_pkg::ST_PRE);
      pre_drive_hi_o <= (stage_reg == acc_pkg::ST_PRE) && (ppol ^ inv);
      guard_o        <= gpol ^ inv;
      acquire_o      <= (stage_reg == acc_pkg::ST_ACQ);
      convert_o      <= (stage_reg == acc_pkg::ST_CONV);
    end
  end

  // ---------------------------------------------------------------
  // computation
  // ---------------------------------------------------------------
  logic        cnt_mode, thr_hit, above, below, irq_cond;
  logic [17:0] sample18, acc_sum, lpf_next;
  logic [18:0] acc_wide;
  logic [7:0]  cnt_next;
  assign cnt_mode = (mode == acc_pkg::MD_AVG) || (mode == acc_pkg::MD_BURST)
                    || (mode == acc_pkg::MD_LPF);
  assign sample18 = {8'h00, conv_data_i};
  // averaging restarts after the count that closed the previous average
  assign acc_wide = {1'b0, ((mode == acc_pkg::MD_AVG || mode == acc_pkg::MD_BURST)
                     && cnt_reg >= rpt_reg && rpt_reg != 8'h00) ? 18'h0 : accum_reg}
                    + {1'b0, sample18};
  assign acc_sum  = acc_wide[17:0];
  assign lpf_next = accum_reg - (accum_reg >> crs) + sample18;
  assign cnt_next = (cnt_reg >= rpt_reg) ? 8'h01 : cnt_reg + 8'h01;
  assign thr_hit  = pair_end && mode != acc_pkg::MD_BASIC
                    && (!cnt_mode || cnt_next >= rpt_reg);
  assign above    = $signed(error_value_i) > $signed(upper_reg);
  assign below    = $signed(error_value_i) < $signed(lower_reg);

  always_comb begin
    case (tmd)
      3'h7:    irq_cond = 1'b1;
      3'h6:    irq_cond = above;
      3'h5:    irq_cond = !above;
      3'h4:    irq_cond = below || above;
      3'h3:    irq_cond = $signed(error_value_i) > $signed(lower_reg) && !above
                          && $signed(error_value_i) != $signed(upper_reg);
      3'h2:    irq_cond = !below;
      3'h1:    irq_cond = below;
      default: irq_cond = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_reg  <= 18'h0;
      filter_reg <= RST_WORD_F;
      result_reg <= RST_WORD_F;
    end else begin
      if (conv_end) begin
        result_reg <= {6'h00, conv_data_i};
      end
      if (clr_busy_reg && tick) begin
        accum_reg <= 18'h0;
      end else if (pair_end) begin
        case (mode)
          acc_pkg::MD_ACCUM, acc_pkg::MD_AVG, acc_pkg::MD_BURST: begin
            accum_reg  <= acc_sum;
            filter_reg <= 16'(acc_sum >> crs);
          end
          acc_pkg::MD_LPF: begin
            accum_reg  <= lpf_next;
            filter_reg <= 16'(lpf_next >> crs);
          end
          default: ;
        endcase
      end
    end
  end

  // previous value captured when the conversion starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= RST_WORD_F;
    end else if (start_evt) begin
      prev_reg <= psis ? filter_reg : result_reg;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_sample_reg <= RST_BYTE_F;
      acc_mode_reg   <= RST_BYTE_F;
      thr_ctrl_reg   <= RST_BYTE_F;
      pre_count_reg  <= RST_BYTE_F;
      rpt_reg        <= RST_BYTE_F;
      lower_reg      <= RST_WORD_F;
      upper_reg      <= RST_WORD_F;
      cont_reg       <= 1'b0;
      clk_src_reg    <= 1'b0;
    end else if (wr) begin
      case (idx)
        acc_pkg::IDX_PRE_SAMPLE: pre_sample_reg <= wbyte & 8'hE1;
        acc_pkg::IDX_ACC_MODE:   acc_mode_reg   <= wbyte & 8'hF7;
        acc_pkg::IDX_THR_CTRL:   thr_ctrl_reg   <= wbyte & 8'h7F;
        acc_pkg::IDX_PRE_COUNT:  pre_count_reg  <= wbyte;
        acc_pkg::IDX_RPT:        rpt_reg        <= wbyte;
        acc_pkg::IDX_LOWER:      lower_reg      <= {hit_high ? wb_dat_i[15:8]
                                                   : lower_reg[15:8], wbyte};
        acc_pkg::IDX_UPPER:      upper_reg      <= {hit_high ? wb_dat_i[15:8]
                                                   : upper_reg[15:8], wbyte};
        acc_pkg::IDX_CONV_CTRL: begin
          cont_reg    <= wbyte[acc_pkg::CC_CONT];
          clk_src_reg <= wbyte[acc_pkg::CC_CS];
        end
        default: ;
      endcase
    end
  end

  // go: software start or stop; hardware clears or retriggers after each pair
  logic stop_hw;
  assign stop_hw = pair_end && (!cont_reg || (soi && thr_hit && irq_cond));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_reg <= 1'b0;
    end else if (wr && idx == acc_pkg::IDX_CONV_CTRL) begin
      go_reg <= wbyte[acc_pkg::CC_GO];
    end else if (stop_hw) begin
      go_reg <= 1'b0;
    end
  end

  // clearing waits for a conversion clock tick so it takes one to four system cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_busy_reg <= 1'b0;
    end else if (clr_busy_reg && tick) begin
      clr_busy_reg <= 1'b0;
    end else if (wr && idx == acc_pkg::IDX_ACC_MODE && wbyte[acc_pkg::AM_ACLR]) begin
      clr_busy_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= RST_BYTE_F;
    end else if (clr_busy_reg && tick) begin
      cnt_reg <= 8'h00;
    end else if (pair_end && cnt_mode) begin
      cnt_reg <= cnt_next;
    end else if (wr && idx == acc_pkg::IDX_CNT) begin
      cnt_reg <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // status flags: hardware set wins over a software clear
  // ---------------------------------------------------------------
  logic ovf_evt, upd_evt, clr_stat;
  assign ovf_evt  = (pair_end && mode != acc_pkg::MD_BASIC
                     && (acc_wide[18] || error_ovf_i));
  assign upd_evt  = pair_end && mode != acc_pkg::MD_BASIC;
  assign clr_stat = wr && idx == acc_pkg::IDX_STATUS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aov_reg  <= 1'b0;
      math_reg <= 1'b0;
      tif_reg  <= 1'b0;
    end else begin
      if (ovf_evt) begin
        aov_reg <= 1'b1;
      end else if (clr_busy_reg && tick) begin
        aov_reg <= 1'b0;
      end else if (clr_stat && wbyte[acc_pkg::ST_AOV]) begin
        aov_reg <= 1'b0;
      end
      if (upd_evt) begin
        math_reg <= 1'b1;
      end else if (clr_stat && wbyte[acc_pkg::ST_MATH]) begin
        math_reg <= 1'b0;
      end
      if (thr_hit && irq_cond) begin
        tif_reg <= 1'b1;
      end else if (clr_stat && wbyte[acc_pkg::ST_TIF]) begin
        tif_reg <= 1'b0;
      end
    end
  end

  // stage code is only meaningful while the system clock outruns the RC clock
  logic [2:0] stage_code;
  always_comb begin
    case (stage_reg)
      acc_pkg::ST_PRE:  stage_code = {second_reg, 2'h1};
      acc_pkg::ST_ACQ:  stage_code = {second_reg, 2'h2};
      acc_pkg::ST_CONV: stage_code = {second_reg, 2'h3};
      default:          stage_code = 3'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus answer, one cycle after the request
  // ---------------------------------------------------------------
  logic [15:0] rdata;
  always_comb begin
    case (idx)
      acc_pkg::IDX_PRE_SAMPLE: rdata = {8'h00, pre_sample_reg};
      acc_pkg::IDX_ACC_MODE:   rdata = {8'h00, acc_mode_reg | {4'h0, clr_busy_reg, 3'h0}};
      acc_pkg::IDX_THR_CTRL:   rdata = {8'h00, thr_ctrl_reg};
      acc_pkg::IDX_PRE_COUNT:  rdata = {8'h00, pre_count_reg};
      acc_pkg::IDX_CONV_CTRL:  rdata = {9'h000, cont_reg, 1'b0, clk_src_reg, 3'h0, go_reg};
      acc_pkg::IDX_PREV:       rdata = prev_reg;
      acc_pkg::IDX_RESULT:     rdata = result_reg;
      acc_pkg::IDX_STATUS:     rdata = {8'h00, aov_reg, above, below, math_reg,
                                        tif_reg, stage_code};
      acc_pkg::IDX_RPT:        rdata = {8'h00, rpt_reg};
      acc_pkg::IDX_CNT:        rdata = {8'h00, cnt_reg};
      acc_pkg::IDX_LOWER:      rdata = lower_reg;
      acc_pkg::IDX_UPPER:      rdata = upper_reg;
      acc_pkg::IDX_ERROR:      rdata = error_value_i;
      acc_pkg::IDX_ACCUM:      rdata = accum_reg[15:0];
      acc_pkg::IDX_FILTER:     rdata = filter_reg;
      default:                 rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
      err_calc_mode_o <= 3'h0;
      thr_flag_o      <= 1'b0;
    end else begin
      wb_ack_o        <= req;
      wb_dat_o        <= (req && !wb_we_i) ? {16'h0000, rdata} : 32'h0000_0000;
      err_calc_mode_o <= thr_ctrl_reg[acc_pkg::TC_CALC +: 3];
      thr_flag_o      <= tif_reg;
    end
  end
endmodule

// ==== bench/acc_compute_ctrl_monitor.sv ====
// Purpose: port assertions for the computation control block
// Assumes: acquisition spans two ticks of 4 clocks, 5 to 8 clocks when started off a tick
// Notes:   bound to acc_compute_ctrl by the bind below
`timescale 1ns/10ps
module acc_mon (
  input wire logic        clk_i,         // clock
  input wire logic        rst_i,         // reset
  input wire logic        wb_stb_i,      // strobe
  input wire logic        wb_ack_o,      // ack
  input wire logic [31:0] wb_dat_o,      // read data
  input wire logic        precharge_o,   // stage
  input wire logic        acquire_o,     // stage
  input wire logic        convert_o,     // stage
  input wire logic        pre_drive_hi_o // drive
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // counts consecutive acquisition cycles, so the length check needs no long repetition
  logic [3:0] acq_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acq_cnt <= 4'h0;
    end else begin
      acq_cnt <= acquire_o ? acq_cnt + 4'h1 : 4'h0;
    end
  end
  sequence s_acq_end;
    !acquire_o && acq_cnt >= 4'h5;
  endsequence
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  a_drive_pre: assert property (pre_drive_hi_o |-> precharge_o)
    else $error("drive outside precharge");
  a_stage_excl: assert property ($onehot0({precharge_o, acquire_o, convert_o}))
    else $error("stages overlap");
  a_acq_len: assert property ($rose(acquire_o) |-> acquire_o [*5] ##[1:4] s_acq_end)
    else $error("acq length");
  a_pre_to_acq: assert property ($fell(precharge_o) |-> acquire_o)
    else $error("precharge not followed by acquisition");
  a_acq_to_conv: assert property ($fell(acquire_o) |-> convert_o)
    else $error("acquisition not followed by conversion");
endmodule
bind acc_compute_ctrl acc_mon u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .precharge_o(precharge_o),
  .acquire_o(acquire_o), .convert_o(convert_o), .pre_drive_hi_o(pre_drive_hi_o));

// ==== bench/acc_analog_model.sv ====
// Purpose: analog core stand-in; Assumes: answers each conversion stage
// Notes: data toggles every cycle outside its hold time, so stale reads show
`timescale 1ns/10ps
module acc_model (
  input  wire logic       clk_i,     // clock
  input  wire logic       convert_i, // conversion stage
  input  wire logic [9:0] val_i,     // value to return
  output logic            done_o,    // conversion done
  output logic      [9:0] data_o     // conversion data
);
  logic [4:0] n = 5'h00;
  initial done_o = 1'b0;
  initial data_o = 10'h155;
  always @(posedge clk_i) begin
    n <= (convert_i || done_o) ? n + 5'h01 : 5'h00;
    done_o <= convert_i && n >= 5'h05;
    data_o <= (n >= 5'h05 && n < 5'h0C) ? val_i : ~data_o;
  end
endmodule

// ==== bench/acc_compute_ctrl_tb.sv ====
// Purpose: self-checking bench; Assumes: 250 MHz clock; Notes: one task a scenario
`timescale 1ns/10ps
module acc_compute_ctrl_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ovf = 1'b0;
  logic        ack, done, pc, dh, gd, cv, tf;
  logic [2:0]  ecm;
  logic [9:0]  val = 10'h000, cdat;
  logic [15:0] err = 16'h0000, rv;
  logic [31:0] adr = 32'h0, wd = 32'h0, rdat;
  int          n_errors = 0;
  int          num_checks = 0;
  acc_compute_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .conv_done_i(done), .conv_data_i(cdat), .error_value_i(err),
    .error_ovf_i(ovf), .precharge_o(pc), .pre_drive_hi_o(dh), .guard_o(gd),
    .acquire_o(), .convert_o(cv), .err_calc_mode_o(ecm), .thr_flag_o(tf));
  acc_model u_mod (.clk_i(clk_i), .convert_i(cv), .val_i(val), .done_o(done), .data_o(cdat));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lim(input int k);
    if (k >= 99) begin
      chk(16'hDEAD, 16'h0000);
      test_done;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {18'h0, idx, 2'h0};
    wd <= {16'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 99);
    lim(k);
    rv = rdat[15:0];
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    chk(rv, e);
  endtask
  task automatic wt(input logic v);
    int k;
    for (k = 0; pc !== v && k < 99; k++) @(posedge clk_i);
    lim(k);
  endtask
  // starts a run, checks drive and guard in each precharge, waits for go to clear
  task automatic go(input logic [1:0] p1, input logic [1:0] p2, input int np, input logic [15:0] c);
    int k;
    bus(1'b1, acc_pkg::IDX_CONV_CTRL, c);
    for (int i = 0; i < np; i++) begin
      wt(1'b1);
      chk({dh, gd}, i == 0 ? p1 : p2);
      wt(1'b0);
    end
    k = 0;
    do begin
      bus(1'b0, acc_pkg::IDX_CONV_CTRL, 16'h0000);
      k++;
    end while (rv[0] !== 1'b0 && k < 99);
    lim(k);
  endtask
  task automatic t_reg;
    rd(acc_pkg::IDX_ACC_MODE, 16'h0000);
    rd(acc_pkg::IDX_STATUS, 16'h0000);
    bus(1'b1, 12'h000, 16'h00FF);
    rd(12'h000, 16'h0000);
    $display("t_reg done");
  endtask
  task automatic t_pol;
    int k;
    bus(1'b1, acc_pkg::IDX_PRE_COUNT, 16'h0001);
    bus(1'b1, acc_pkg::IDX_RPT, 16'h0008);
    bus(1'b1, acc_pkg::IDX_ACC_MODE, 16'h0032);
    bus(1'b1, acc_pkg::IDX_PRE_SAMPLE, 16'h00A0);
    val <= 10'h2A5;
    go(2'b11, 2'b11, 1, 16'h0001);
    rd(acc_pkg::IDX_RESULT, 16'h02A5);
    bus(1'b1, acc_pkg::IDX_PRE_SAMPLE, 16'h00E1);
    go(2'b11, 2'b00, 2, 16'h0001);
    rd(acc_pkg::IDX_CNT, 16'h0002);
    bus(1'b1, acc_pkg::IDX_PRE_SAMPLE, 16'h0000);
    go(2'b00, 2'b00, 1, 16'h0001);
    bus(1'b1, acc_pkg::IDX_ACC_MODE, 16'h003A);
    // clearing waits for a conversion tick; poll until hardware drops the bit
    k = 0;
    do begin
      bus(1'b0, acc_pkg::IDX_ACC_MODE, 16'h0000);
      k++;
    end while (rv[3] !== 1'b0 && k < 99);
    lim(k);
    rd(acc_pkg::IDX_ACC_MODE, 16'h0032);
    rd(acc_pkg::IDX_CNT, 16'h0000);
    rd(acc_pkg::IDX_ACCUM, 16'h0000);
    $display("t_pol done");
  endtask
  task automatic t_acc;
    bus(1'b1, acc_pkg::IDX_ACC_MODE, 16'h0019);
    bus(1'b1, acc_pkg::IDX_PRE_COUNT, 16'h0000);
    val <= 10'h005;
    go(2'b00, 2'b00, 0, 16'h0001);
    val <= 10'h007;
    go(2'b00, 2'b00, 0, 16'h0001);
    rd(acc_pkg::IDX_ACCUM, 16'h000C);
    rd(acc_pkg::IDX_FILTER, 16'h0006);
    rd(acc_pkg::IDX_PREV, 16'h0005);
    rd(acc_pkg::IDX_STATUS, 16'h0010);
    bus(1'b1, acc_pkg::IDX_STATUS, 16'h0010);
    rd(acc_pkg::IDX_STATUS, 16'h0000);
    $display("t_acc done");
  endtask
  task automatic t_thr;
    bus(1'b1, acc_pkg::IDX_LOWER, 16'hFFFE);
    bus(1'b1, acc_pkg::IDX_UPPER, 16'h000A);
    err <= 16'h0014;
    bus(1'b1, acc_pkg::IDX_THR_CTRL, 16'h0056);
    @(posedge clk_i);
    chk({13'h0, ecm}, 16'h0005);
    go(2'b00, 2'b00, 0, 16'h0001);
    rd(acc_pkg::IDX_STATUS, 16'h0058);
    chk({15'h0, tf}, 16'h0001);
    bus(1'b1, acc_pkg::IDX_STATUS, 16'h0018);
    err <= 16'hFFF0;
    bus(1'b1, acc_pkg::IDX_THR_CTRL, 16'h0009);
    go(2'b00, 2'b00, 0, 16'h0041);
    rd(acc_pkg::IDX_STATUS, 16'h0038);
    $display("t_thr done");
  endtask
  // filter mode with previous value from the filter output and an error overflow
  task automatic t_lpf;
    bus(1'b1, acc_pkg::IDX_ACC_MODE, 16'h009C);
    val <= 10'h008;
    ovf <= 1'b1;
    go(2'b00, 2'b00, 0, 16'h0001);
    ovf <= 1'b0;
    go(2'b00, 2'b00, 0, 16'h0001);
    rd(acc_pkg::IDX_PREV, 16'h0004);
    rd(acc_pkg::IDX_FILTER, 16'h0006);
    rd(acc_pkg::IDX_ACCUM, 16'h000C);
    rd(acc_pkg::IDX_STATUS, 16'h00B8);
    bus(1'b1, acc_pkg::IDX_STATUS, 16'h0080);
    rd(acc_pkg::IDX_STATUS, 16'h0038);
    $display("t_lpf done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reg;
    t_pol;
    t_acc;
    t_thr;
    t_lpf;
    test_done;
  end
endmodule
